// File: logic/edx_consts.svh
/*
  timing counts, register offsets and field positions for the event delay
  and signal export block. assumes inclusion by bare name.
*/
`ifndef EDX_CONSTS_SVH
`define EDX_CONSTS_SVH

// analog path latency in sample clock periods
`define EDX_START_LATENCY     44
// event delay range in periods
`define EDX_DLY_W             8
`define EDX_DLY_MAX           255
// pipeline length covers latency plus largest delay
`define EDX_PIPE_LEN          300
// timebase divider bounds and default
`define EDX_DIV_W             23
`define EDX_DIV_MIN           23'h00_0002
`define EDX_DIV_MAX           23'h40_0000
`define EDX_DIV_DEF           23'h00_0002
// destination counts
`define EDX_NUM_TRIG          7
`define EDX_NUM_DEST          12
// register byte offsets
`define EDX_REG_CTRL          12'h000
`define EDX_REG_DELAY         12'h004
`define EDX_REG_SCDIV         12'h008
`define EDX_REG_TBDIV         12'h00C
`define EDX_REG_ROUTE0        12'h010
`define EDX_REG_ROUTE1        12'h014
`define EDX_REG_STATUS        12'h018
// control field positions
`define EDX_CTRL_ARB_MODE     0
`define EDX_CTRL_PLL_SEL      1
`define EDX_CTRL_DDC_FIT      2
`define EDX_CTRL_ARM          3
// bus responses
`define EDX_RESP_OKAY         2'h0
`define EDX_RESP_SLVERR       2'h2

`endif

// File: logic/edx_pkg.sv
/*
  types for the event delay and signal export block.
  assumes the constants header is on the include path.
*/
`include "edx_consts.svh"

package edx_pkg;

  // export source selector, one per destination
  typedef enum logic [3:0] {
    EDX_SRC_NONE,
    EDX_SRC_SCLK,
    EDX_SRC_SCLK_DIV,
    EDX_SRC_TB_DIV,
    EDX_SRC_PLL_REF,
    EDX_SRC_START,
    EDX_SRC_MARKER,
    EDX_SRC_STARTED,
    EDX_SRC_DONE,
    EDX_SRC_DMARK0,
    EDX_SRC_DMARK1
  } edx_src_t;

  // event delays in whole sample clock periods
  typedef struct packed {
    logic [`EDX_DLY_W-1:0] marker;
    logic [`EDX_DLY_W-1:0] started;
    logic [`EDX_DLY_W-1:0] done;
  } edx_delay_t;

  // raw events from the generation core
  typedef struct packed {
    logic marker;
    logic started;
    logic done;
    logic [1:0] dmark;
  } edx_events_t;

  // generation state
  typedef enum logic [1:0] {
    EDX_IDLE,
    EDX_FILL,
    EDX_RUN
  } edx_state_t;

endpackage

// File: logic/edx_divider.sv
/*
  integer clock divider producing a roughly square enable-rate signal.
  assumes ratio is at least 2 and held steady; runs on the block clock.
*/
`timescale 1ns/1ps
`include "edx_consts.svh"

module edx_divider #(
  parameter int W = `EDX_DIV_W
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  output logic              div_out
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         out_r;
  logic         out_nxt;

  // count ticks, high for the first half of the ratio
  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (tick) begin
      if (cnt_r >= ratio - W'(1)) begin
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
      out_nxt = (cnt_nxt < (ratio >> 1));
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign div_out = out_r;

endmodule

// File: logic/edx_top.sv
/*
  event delay and signal export: delays marker, started and done events in
  whole sample periods behind the analog output and routes clocks, triggers
  and events to seven trigger lines, two front pins, two data connector pins
  and the clock output. assumes one clock, sample_en marking each sample
  clock period, and an axi4-lite master for configuration.
*/
//
// Contract
// - start to analog output at least 44 periods
// - marker, started, done events get programmable delay
// - delay zero aligns; N delays N periods
// - delays counted in whole sample periods only
// - delay latched at start, not recomputed mid-run
// - alignment exact on first selected terminal
// - seven independently selectable trigger line outputs
// - undivided sample clock only on clock output
// - timebase always divided to lines and pins
// - timebase divider default 2, range 2..4194304
// - sample clock derived from 200-400 MHz timebase
// - pll reference exported only when selected
// - start trigger output routable to lines, pins
// - marker only in arb mode, never clock out
// - marker tied to one sample position
// - data markers on pins 4,5 only with connector
// - each sample edge converts next memory value
`timescale 1ns/1ps
`include "edx_consts.svh"

module edx_top #(
  parameter int PIPE = `EDX_PIPE_LEN
) (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      ce,
  input  wire logic                      sample_en,
  input  wire logic                      timebase_tick,
  input  wire logic                      sclk_level,
  input  wire logic                      pll_ref_in,
  input  wire logic                      start_req,
  input  wire edx_pkg::edx_events_t      events_in,
  input  wire logic [15:0]               wave_in,
  output logic [15:0]                    dac_data,
  output logic [`EDX_NUM_TRIG-1:0]       trig_out,
  output logic [`EDX_NUM_TRIG-1:0]       trig_oe,
  output logic [3:0]                     pin_out,
  output logic [3:0]                     pin_oe,
  output logic                           clk_out,
  output logic                           clk_oe,
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);

  // byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        old[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return old;
  endfunction

  // ---------------- register file ----------------
  logic [31:0]               ctrl_r, ctrl_nxt;
  logic [31:0]               delay_r, delay_nxt;
  logic [`EDX_DIV_W-1:0]     scdiv_r, scdiv_nxt;
  logic [`EDX_DIV_W-1:0]     tbdiv_r, tbdiv_nxt;
  logic [31:0]               route0_r, route0_nxt;
  logic [31:0]               route1_r, route1_nxt;
  logic                      aw_held_r, aw_held_nxt;
  logic [11:0]               aw_addr_r, aw_addr_nxt;
  logic                      w_held_r, w_held_nxt;
  logic [31:0]               w_data_r, w_data_nxt;
  logic [3:0]                w_strb_r, w_strb_nxt;
  logic                      bvalid_r, bvalid_nxt;
  logic [1:0]                bresp_r, bresp_nxt;
  logic                      rvalid_r, rvalid_nxt;
  logic [31:0]               rdata_r, rdata_nxt;
  logic [1:0]                rresp_r, rresp_nxt;
  logic [31:0]               wmerged;
  logic [31:0]               status_word;
  edx_pkg::edx_state_t       state_r, state_nxt;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // axi4-lite slave: address and data in either order, write on both
  always_comb begin
    ctrl_nxt    = ctrl_r;
    delay_nxt   = delay_r;
    scdiv_nxt   = scdiv_r;
    tbdiv_nxt   = tbdiv_r;
    route0_nxt  = route0_r;
    route1_nxt  = route1_r;
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    wmerged     = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (aw_held_r && w_held_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `EDX_RESP_OKAY;
      unique case ({aw_addr_r[11:2], 2'b00})
        `EDX_REG_CTRL: ctrl_nxt = merge(ctrl_r, w_data_r, w_strb_r);
        `EDX_REG_DELAY: begin
          // delays frozen while generating
          if (state_r == edx_pkg::EDX_IDLE) begin
            delay_nxt = merge(delay_r, w_data_r, w_strb_r);
          end
        end
        `EDX_REG_SCDIV: begin
          wmerged   = merge({9'h000, scdiv_r}, w_data_r, w_strb_r);
          scdiv_nxt = wmerged[`EDX_DIV_W-1:0];
        end
        `EDX_REG_TBDIV: begin
          wmerged = merge({9'h000, tbdiv_r}, w_data_r, w_strb_r);
          // out-of-range ratio refused
          if (wmerged >= {9'h000, `EDX_DIV_MIN} && wmerged <= {9'h000, `EDX_DIV_MAX}) begin
            tbdiv_nxt = wmerged[`EDX_DIV_W-1:0];
          end else begin
            bresp_nxt = `EDX_RESP_SLVERR;
          end
        end
        `EDX_REG_ROUTE0: route0_nxt = merge(route0_r, w_data_r, w_strb_r);
        `EDX_REG_ROUTE1: route1_nxt = merge(route1_r, w_data_r, w_strb_r);
        default: bresp_nxt = `EDX_RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `EDX_RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `EDX_REG_CTRL:   rdata_nxt = ctrl_r;
        `EDX_REG_DELAY:  rdata_nxt = delay_r;
        `EDX_REG_SCDIV:  rdata_nxt = {9'h000, scdiv_r};
        `EDX_REG_TBDIV:  rdata_nxt = {9'h000, tbdiv_r};
        `EDX_REG_ROUTE0: rdata_nxt = route0_r;
        `EDX_REG_ROUTE1: rdata_nxt = route1_r;
        `EDX_REG_STATUS: rdata_nxt = status_word;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `EDX_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r    <= 32'h0000_0000;
      delay_r   <= 32'h0000_0000;
      scdiv_r   <= `EDX_DIV_DEF;
      tbdiv_r   <= `EDX_DIV_DEF;
      route0_r  <= 32'h0000_0000;
      route1_r  <= 32'h0000_0000;
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'h0;
    end else if (ce) begin
      ctrl_r    <= ctrl_nxt;
      delay_r   <= delay_nxt;
      scdiv_r   <= scdiv_nxt;
      tbdiv_r   <= tbdiv_nxt;
      route0_r  <= route0_nxt;
      route1_r  <= route1_nxt;
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ---------------- generation and delay pipeline ----------------
  logic [PIPE-1:0]           mk_pipe_r, mk_pipe_nxt;
  logic [PIPE-1:0]           st_pipe_r, st_pipe_nxt;
  logic [PIPE-1:0]           dn_pipe_r, dn_pipe_nxt;
  logic [15:0]               wave_pipe_r [`EDX_START_LATENCY];
  logic [15:0]               wave_tail;
  logic [8:0]                fill_r, fill_nxt;
  edx_pkg::edx_delay_t       dly_r, dly_nxt;
  logic [1:0]                dm_r, dm_nxt;
  logic                      start_pulse;
  logic                      ev_marker, ev_started, ev_done;

  assign start_pulse = start_req && (state_r == edx_pkg::EDX_IDLE) && ctrl_r[`EDX_CTRL_ARM];

  // shift events once per sample period; delay latched at start
  always_comb begin
    state_nxt   = state_r;
    fill_nxt    = fill_r;
    dly_nxt     = dly_r;
    mk_pipe_nxt = mk_pipe_r;
    st_pipe_nxt = st_pipe_r;
    dn_pipe_nxt = dn_pipe_r;
    dm_nxt      = dm_r;
    if (start_pulse) begin
      state_nxt = edx_pkg::EDX_FILL;
      fill_nxt  = 9'h000;
      dly_nxt   = edx_pkg::edx_delay_t'(delay_r[3*`EDX_DLY_W-1:0]);
    end
    if (sample_en) begin
      mk_pipe_nxt = {mk_pipe_r[PIPE-2:0], events_in.marker};
      st_pipe_nxt = {st_pipe_r[PIPE-2:0], events_in.started};
      dn_pipe_nxt = {dn_pipe_r[PIPE-2:0], events_in.done};
      dm_nxt      = events_in.dmark;
      if (state_r == edx_pkg::EDX_FILL) begin
        fill_nxt = fill_r + 9'h001;
        if (fill_r == 9'(`EDX_START_LATENCY - 1)) begin
          state_nxt = edx_pkg::EDX_RUN;
        end
      end
    end
    if (!ctrl_r[`EDX_CTRL_ARM] && state_r != edx_pkg::EDX_IDLE) begin
      state_nxt = edx_pkg::EDX_IDLE;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r   <= edx_pkg::EDX_IDLE;
      fill_r    <= 9'h000;
      dly_r     <= '0;
      mk_pipe_r <= '0;
      st_pipe_r <= '0;
      dn_pipe_r <= '0;
      dm_r      <= 2'h0;
    end else if (ce) begin
      state_r   <= state_nxt;
      fill_r    <= fill_nxt;
      dly_r     <= dly_nxt;
      mk_pipe_r <= mk_pipe_nxt;
      st_pipe_r <= st_pipe_nxt;
      dn_pipe_r <= dn_pipe_nxt;
      dm_r      <= dm_nxt;
    end
  end

  // waveform path: one new value per sample edge, 44 periods deep
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `EDX_START_LATENCY; i++) begin
        wave_pipe_r[i] <= 16'h0000;
      end
    end else if (ce && sample_en) begin
      wave_pipe_r[0] <= wave_in;
      for (int i = 1; i < `EDX_START_LATENCY; i++) begin
        wave_pipe_r[i] <= wave_pipe_r[i-1];
      end
    end
  end

  assign wave_tail = wave_pipe_r[`EDX_START_LATENCY-1];
  assign dac_data  = wave_tail;

  // tap = analog latency + programmed delay
  assign ev_marker  = mk_pipe_r[`EDX_START_LATENCY - 1 + int'(dly_r.marker)];
  assign ev_started = st_pipe_r[`EDX_START_LATENCY - 1 + int'(dly_r.started)];
  assign ev_done    = dn_pipe_r[`EDX_START_LATENCY - 1 + int'(dly_r.done)];

  // ---------------- dividers ----------------
  logic sclk_div, tb_div;

  edx_divider #(.W(`EDX_DIV_W)) u_scdiv (
    .clock   (clock),
    .reset   (reset),
    .ce      (ce),
    .tick    (sample_en),
    .ratio   (scdiv_r),
    .div_out (sclk_div)
  );

  // timebase never leaves undivided
  edx_divider #(.W(`EDX_DIV_W)) u_tbdiv (
    .clock   (clock),
    .reset   (reset),
    .ce      (ce),
    .tick    (timebase_tick),
    .ratio   (tbdiv_r),
    .div_out (tb_div)
  );

  // ---------------- routing ----------------
  logic [`EDX_NUM_DEST-1:0] dst_val, dst_en;
  logic                     sc_div_ok;

  assign sc_div_ok = (scdiv_r >= `EDX_DIV_MIN);

  // source value and legality per destination class
  function automatic logic [1:0] pick(input edx_pkg::edx_src_t s, input logic is_clk,
                                      input logic sv, input logic sd, input logic tb,
                                      input logic pll, input logic st, input logic mk,
                                      input logic sd2, input logic dn, input logic [1:0] dm,
                                      input logic pll_ok, input logic arb, input logic dm_ok,
                                      input logic sc_ok);
    unique case (s)
      edx_pkg::EDX_SRC_SCLK:     return {sv, is_clk};
      edx_pkg::EDX_SRC_SCLK_DIV: return {sd, sc_ok};
      edx_pkg::EDX_SRC_TB_DIV:   return {tb, 1'b1};
      edx_pkg::EDX_SRC_PLL_REF:  return {pll, pll_ok};
      edx_pkg::EDX_SRC_START:    return {st, !is_clk};
      edx_pkg::EDX_SRC_MARKER:   return {mk, !is_clk && arb};
      edx_pkg::EDX_SRC_STARTED:  return {sd2, !is_clk};
      edx_pkg::EDX_SRC_DONE:     return {dn, !is_clk};
      edx_pkg::EDX_SRC_DMARK0:   return {dm[0], !is_clk && dm_ok};
      edx_pkg::EDX_SRC_DMARK1:   return {dm[1], !is_clk && dm_ok};
      default:                   return 2'b00;
    endcase
  endfunction

  // one selector per destination, unselected stays undriven
  always_comb begin
    logic [1:0] r;
    logic       dmok;
    r = 2'b00;
    dmok = 1'b0;
    for (int d = 0; d < `EDX_NUM_DEST; d++) begin
      dmok = (d < 9) || ctrl_r[`EDX_CTRL_DDC_FIT];
      r = pick(edx_pkg::edx_src_t'((d < 8) ? route0_r[d*4 +: 4] : route1_r[(d-8)*4 +: 4]),
               d == `EDX_NUM_DEST - 1, sclk_level, sclk_div, tb_div, pll_ref_in,
               start_pulse, ev_marker, ev_started, ev_done, dm_r,
               ctrl_r[`EDX_CTRL_PLL_SEL], ctrl_r[`EDX_CTRL_ARB_MODE] && d < 9, dmok, sc_div_ok);
      dst_val[d] = r[1];
      dst_en[d]  = r[0];
    end
  end

  // each event has its own tap, shared by every terminal that selects it
  assign trig_out = dst_val[6:0] & dst_en[6:0];
  assign trig_oe  = dst_en[6:0];
  assign pin_out  = dst_val[10:7] & dst_en[10:7];
  assign pin_oe   = dst_en[10:7];
  assign clk_out  = dst_val[11] & dst_en[11];
  assign clk_oe   = dst_en[11];

  // status: busy flag, fill count, divided timebase
  assign status_word = {20'h0_0000, fill_r, tb_div, 1'b0, 1'(state_r != edx_pkg::EDX_IDLE)};

endmodule

// File: tb/edx_top_assertions.sv
/*
  checker for the export block: bus handshakes and output gating.
  assumes a bind onto edx_top, one clock, async active-high reset.
*/
`timescale 1ns/1ps
module edx_top_assertions (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [6:0]  trig_out,
  input wire logic [6:0]  trig_oe,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe,
  input wire logic        clk_out,
  input wire logic        clk_oe,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // destinations carry a level only while enabled
  trig_gate_a: assert property ((trig_out & ~trig_oe) == 7'h0)
    else $error("trigger line level without enable");
  pin_gate_a: assert property ((pin_out & ~pin_oe) == 4'h0)
    else $error("front pin level without enable");
  clk_gate_a: assert property (clk_oe || !clk_out)
    else $error("clock output level without enable");
  // answers stand until taken
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata})) else $error("read answer dropped");
  // answers follow requests within a fixed time
  rd_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  // no new request taken while an answer waits
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (trig_oe[0] && trig_out[0]);
endmodule

// File: tb/edx_far_end.sv
/*
  far-end model: other instruments on the trigger lines and front pins.
  assumes the block clock; a released line shows a level that flips each cycle.
*/
`timescale 1ns/1ps
module edx_far_end (
  input  wire logic       clock,
  input  wire logic [6:0] trig_out,
  input  wire logic [6:0] trig_oe,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  output logic      [6:0] trig_line,
  output logic      [3:0] pin_line
);
  logic [10:0] idle_r = 11'h000;
  // released lines flip so a stale level is never read as driven
  always_ff @(posedge clock) idle_r <= ~idle_r;
  // receivers see the driven level only while enabled
  assign trig_line = (trig_out & trig_oe) | (idle_r[6:0] & ~trig_oe);
  assign pin_line  = (pin_out & pin_oe) | (idle_r[10:7] & ~pin_oe);
  // lines move at most once per 100 ns cycle, under the backplane limit
endmodule

// File: tb/tb_top.sv
/*
  testbench for the event delay and signal export block.
  assumes the package and constants header are compiled and on the path.
*/
`timescale 1ns/1ps
`include "edx_consts.svh"
module tb_top;
  logic        clock = 1'b0, reset = 1'b1, ce = 1'b1, sample_en = 1'b1, start_req = 1'b0;
  logic        timebase_tick = 1'b0, sclk_level = 1'b0, pll_ref_in = 1'b0;
  edx_pkg::edx_events_t events_in = '0;
  logic [15:0] wave_in = 16'h0000, dac_data;
  logic [6:0]  trig_out, trig_oe, trig_line;
  logic [3:0]  pin_out, pin_oe, pin_line, s_axi_wstrb = 4'hF;
  logic        clk_out, clk_oe, snap = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tp = 2'h0;
  logic [2:0]  fire = 3'h0;
  int          n_fail = 0, num_checks = 0, cyc = 0, t_in = 0, t0 = 0;
  int          starts = 0, rises = 0, seed = 47, qe[$], dl[3] = '{0, 2, 255};
  logic [1:0]  qb[$];
  logic [33:0] qr[$];
  logic [11:0] qo[$];

  edx_top i_dut (.clock, .reset, .ce, .sample_en, .timebase_tick, .sclk_level, .pll_ref_in,
    .start_req, .events_in, .wave_in, .dac_data, .trig_out, .trig_oe, .pin_out, .pin_oe,
    .clk_out, .clk_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  edx_far_end i_far (.clock, .trig_out, .trig_oe, .pin_out, .pin_oe, .trig_line, .pin_line);

  always #50 clock = ~clock;

  // random waveform, data markers and clock sources; tagged sample on request
  always @(posedge clock) begin
    cyc <= cyc + 1;
    wave_in <= (|fire) ? 16'hBEEF : 16'($random(seed)) & 16'h7FFF;
    events_in <= {fire, 2'($random(seed))};
    {timebase_tick, sclk_level, pll_ref_in} <= 3'($random(seed));
  end

  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // watcher: takes the oldest note whenever a result appears
  always @(posedge clock) begin
    if (wave_in === 16'hBEEF) t_in = cyc;
    if (dac_data === 16'hBEEF) begin
      t0 = cyc;
      chk(t0 - t_in >= 44 && t0 - t_in <= 45, "analog latency");
    end
    if (trig_oe[0] === 1'b1 && trig_line[0] && !tp[0] && qe.size() > 0)
      chk(cyc - t0 === qe.pop_front(), "event delay");
    if (trig_oe[1] === 1'b1 && trig_line[1] && !tp[1]) rises++;
    tp <= trig_line[1:0];
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp === qb.pop_front(), "write response");
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata} === qr.pop_front(), "read answer");
    if (snap) chk({clk_oe, pin_oe, trig_oe} === qo.pop_front(), "output enables");
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    bit ad, wd;
    ad = 0;
    wd = 0;
    qb.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    qr.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask

  // e is {clk_oe, pin_oe, trig_oe}
  task automatic route(input logic [31:0] c, r0, r1, input logic [11:0] e);
    wr(`EDX_REG_CTRL, c);
    wr(`EDX_REG_ROUTE0, r0);
    wr(`EDX_REG_ROUTE1, r1);
    qo.push_back(e);
    snap <= 1'b1;
    @(posedge clock);
    snap <= 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  // main sequence: registers, routing table, delayed events
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(`EDX_REG_TBDIV, {2'h0, 32'h0000_0002});
    rd(`EDX_REG_SCDIV, {2'h0, 32'h0000_0002});
    wr(`EDX_REG_TBDIV, 32'h0000_0001, `EDX_RESP_SLVERR);
    wr(`EDX_REG_TBDIV, 32'h0040_0001, `EDX_RESP_SLVERR);
    rd(`EDX_REG_TBDIV, {2'h0, 32'h0000_0002});
    wr(`EDX_REG_TBDIV, 32'h0040_0000);
    rd(`EDX_REG_TBDIV, {2'h0, 32'h0040_0000});
    wr(12'h01C, 32'h0000_0001, `EDX_RESP_SLVERR);
    rd(12'h01C, {`EDX_RESP_SLVERR, 32'h0000_0000});
    $display("test registers done");
    route(32'h0000_0002, 32'h0404_0404, 32'h0000_0000, 12'h055);
    route(32'h0000_0000, 32'h4000_0004, 32'h0000_4000, 12'h000);
    route(32'h0000_0002, 32'h4000_0004, 32'h0000_4000, 12'h881);
    route(32'h0000_0000, 32'h1000_0001, 32'h0000_1001, 12'h800);
    route(32'h0000_0000, 32'h0000_0002, 32'h0000_0000, 12'h001);
    route(32'h0000_0000, 32'h0000_0003, 32'h0000_3000, 12'h801);
    route(32'h0000_0001, 32'h0000_0006, 32'h0000_6000, 12'h001);
    route(32'h0000_0001, 32'h9000_0000, 32'h0000_00A0, 12'h080);
    route(32'h0000_0005, 32'h9000_0000, 32'h0000_00A0, 12'h280);
    $display("test routing done");
    for (int s = 0; s < 3; s++)
      foreach (dl[i]) begin
        wr(`EDX_REG_CTRL, 32'h0000_0000);
        wr(`EDX_REG_DELAY, {8'h00, {3{8'(dl[i])}}});
        route(32'h0000_0009, 32'h0000_0050 | (6 + s), 32'h0000_0000, 12'h003);
        start_req <= 1'b1;
        @(posedge clock);
        start_req <= 1'b0;
        starts++;
        wr(`EDX_REG_DELAY, {8'h00, {3{8'(dl[i] + 1)}}});
        repeat (60) @(posedge clock);
        qe.push_back(dl[i]);
        fire <= 3'b100 >> s;
        @(posedge clock);
        fire <= 3'h0;
        repeat (320) @(posedge clock);
        $display("test event source %0d delay %0d done", 6 + s, dl[i]);
      end
    chk(rises === starts && qe.size() == 0, "start pulses or events missing");
    summarize();
  end
endmodule

bind edx_top edx_top_assertions i_chk (.clock, .reset, .ce, .trig_out, .trig_oe, .pin_out,
  .pin_oe, .clk_out, .clk_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
